/* File: dv/tb_tswd_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tswd_map.svh"
module tb_tswd_top;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        halt_req = 1'b0;
    logic        dbg_halt;
    logic        irq;
    logic        sys_rst_out;
    logic        rst_seen;
    logic [31:0] rd;
    logic [31:0] v1;
    logic        err;
    int          bad_count = 0;
    int          compares = 0;

    always #4 mclk = ~mclk;

    tswd_top i_tswd_top(.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt), .irq(irq),
        .sys_rst_out(sys_rst_out));
    tswd_sys_model i_tswd_sys_model(.mclk(mclk), .rst(rst), .halt_req(halt_req),
        .sys_rst_out(sys_rst_out), .dbg_halt(dbg_halt), .rst_seen(rst_seen));

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            chkb("pready", 1'b1, 1'b0);
            summarize();
        end
        else
            @(posedge mclk);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic waitb(input logic sel_rst, input string nm);
        int n;
        n = 0;
        while ((sel_rst ? sys_rst_out : irq) !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        chkb(nm, 1'b1, sel_rst ? sys_rst_out : irq);
        if (n >= 40)
            summarize();
    endtask

    task automatic step3(input logic [31:0] d);
        xfer(1'b0, `TSWD_VALUE_OFF, 32'h0);
        v1 = rd;
        rchk("value_step", `TSWD_VALUE_OFF, v1 - d);
    endtask

    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rchk("load_rst", `TSWD_LOAD_OFF, `TSWD_LOAD_RST);
        rchk("lock_rst", `TSWD_LOCK_OFF, 32'h0);
        rchk("unmapped", 8'h1c, 32'h0);
        chkb("slverr", 1'b1, err);
        xfer(1'b1, `TSWD_LOAD_OFF, 32'h3e8);
        xfer(1'b1, `TSWD_CTRL_OFF, 32'h1);
        rchk("mask_on_en", `TSWD_IMASK_OFF, 32'h1);
        step3(32'h3);
        xfer(1'b1, `TSWD_LOAD_OFF, 32'h1f4);
        xfer(1'b0, `TSWD_VALUE_OFF, 32'h0);
        chk("value_reload", 32'h1f3, rd);
        xfer(1'b1, `TSWD_LOAD_OFF, 32'ha);
        waitb(1'b0, "irq_first");
        @(posedge mclk);
        rchk("ris_set", `TSWD_RIS_OFF, 32'h1);
        rchk("mis_set", `TSWD_MIS_OFF, 32'h1);
        xfer(1'b0, `TSWD_VALUE_OFF, 32'h0);
        chkb("value_le_load", 1'b1, rd <= 32'ha);
        xfer(1'b1, `TSWD_RIS_OFF, 32'h1);
        chkb("irq_cleared", 1'b0, irq);
        waitb(1'b0, "irq_again");
        chkb("no_rst_disabled", 1'b0, sys_rst_out);
        xfer(1'b1, `TSWD_IMASK_OFF, 32'h0);
        chkb("irq_masked", 1'b0, irq);
        rchk("mis_masked", `TSWD_MIS_OFF, 32'h0);
        xfer(1'b1, `TSWD_CTRL_OFF, 32'h3);
        waitb(1'b1, "sys_rst");
        @(posedge mclk);
        chkb("rst_seen", 1'b1, rst_seen);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chkb("sys_rst_clr", 1'b0, sys_rst_out);
        xfer(1'b1, `TSWD_LOCK_OFF, 32'h0);
        rchk("locked", `TSWD_LOCK_OFF, 32'h1);
        xfer(1'b1, `TSWD_LOAD_OFF, 32'h5);
        rchk("load_locked", `TSWD_LOAD_OFF, `TSWD_LOAD_RST);
        xfer(1'b1, `TSWD_CTRL_OFF, 32'h1);
        rchk("ctrl_locked", `TSWD_CTRL_OFF, 32'h0);
        xfer(1'b1, `TSWD_LOCK_OFF, `TSWD_UNLOCK_KEY);
        rchk("unlocked", `TSWD_LOCK_OFF, 32'h0);
        xfer(1'b1, `TSWD_LOAD_OFF, 32'h0);
        rchk("zero_load", `TSWD_RIS_OFF, 32'h1);
        xfer(1'b1, `TSWD_RIS_OFF, 32'h1);
        xfer(1'b1, `TSWD_LOAD_OFF, 32'h64);
        xfer(1'b1, `TSWD_CTRL_OFF, 32'h5);
        halt_req <= 1'b1;
        repeat (3) @(posedge mclk);
        step3(32'h0);
        halt_req <= 1'b0;
        repeat (3) @(posedge mclk);
        step3(32'h3);
        xfer(1'b0, `TSWD_VALUE_OFF, 32'h0);
        v1 = rd;
        ce <= 1'b0;
        repeat (5) @(posedge mclk);
        ce <= 1'b1;
        rchk("value_ce_hold", `TSWD_VALUE_OFF, v1 - 32'h3);
        summarize();
    end
endmodule
`default_nettype wire

/* File: dv/tswd_sys_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tswd_sys_model
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic halt_req,
    input  wire logic sys_rst_out,
    output logic      dbg_halt,
    output logic      rst_seen
);
    always_ff @(posedge mclk)
    begin
        dbg_halt <= halt_req;
        if (rst)
            rst_seen <= 1'b0;
        else if (sys_rst_out)
            rst_seen <= 1'b1;
    end
endmodule
`default_nettype wire

/* File: rtl/tswd_map.svh */
`ifndef TSWD_MAP_SVH
`define TSWD_MAP_SVH

`define TSWD_CNT_W        32
`define TSWD_ADDR_W       8

`define TSWD_LOAD_OFF     8'h00
`define TSWD_VALUE_OFF    8'h04
`define TSWD_CTRL_OFF     8'h08
`define TSWD_RIS_OFF      8'h0c
`define TSWD_IMASK_OFF    8'h10
`define TSWD_MIS_OFF      8'h14
`define TSWD_LOCK_OFF     8'h18

`define TSWD_CTRL_EN_BIT  0
`define TSWD_CTRL_RST_BIT 1
`define TSWD_CTRL_STL_BIT 2
`define TSWD_TMO_BIT      0

`define TSWD_LOAD_RST     32'hffff_ffff
`define TSWD_UNLOCK_KEY   32'h1acc_e551

`endif

/* File: rtl/tswd_pkg.sv */
`include "tswd_map.svh"

package tswd_pkg;

    typedef logic [`TSWD_CNT_W-1:0] tswd_word_type;

    typedef struct packed {
        tswd_word_type load;
        tswd_word_type cnt;
        logic          en;
        logic          rst_en;
        logic          stall_en;
        logic          locked;
        logic          raw;
        logic          mask;
        logic          irq;
        logic          sys_rst;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
    } tswd_state_type;

endpackage

/* File: rtl/tswd_top.sv */
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tswd_map.svh"

// Summary of operation
// - The block holds a 32-bit down counter, a reload register, interrupt logic and a lock.
// - While locked, writes to reload, control and mask are ignored.
// - The first timeout raises an interrupt and a second one can drive a system reset.
// - Once enabled, the first timeout occurs when the counter reaches zero.
// - Enabling the counter also enables the timeout interrupt.
// - At the first timeout the counter reloads from the reload register and keeps counting.
// - Zero reached again with the interrupt uncleared and reset enabled asserts system reset.
// - Clearing the interrupt before the second zero lets the counter reload and carry on.
// - Writing the reload register while running loads the counter at once.
// - Writing a reload value of zero raises the timeout interrupt immediately.
// - With stalling enabled the counter holds while the debugger halts the processor.
// - Software can read whether the configuration is locked.
// - Raw and masked interrupt status are both readable.
module tswd_top
(
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   dbg_halt,
    output logic                        irq,
    output logic                        sys_rst_out
);

    tswd_pkg::tswd_state_type r_reg;
    tswd_pkg::tswd_state_type r_next;

    logic                    wr_acc;
    logic                    setup;
    logic                    running;
    logic                    tick;
    logic [`TSWD_ADDR_W-1:0] a;
    logic                    hit_load;
    logic                    hit_ctrl;
    logic                    hit_ris;
    logic                    hit_mask;
    logic                    hit_lock;
    logic                    mapped;
    logic                    load_wr;
    logic                    clr_tmo;
    logic                    set_tmo;
    logic [31:0]             rdata;

    assign a        = paddr[`TSWD_ADDR_W-1:0];
    assign hit_load = (a == `TSWD_LOAD_OFF);
    assign hit_ctrl = (a == `TSWD_CTRL_OFF);
    assign hit_ris  = (a == `TSWD_RIS_OFF);
    assign hit_mask = (a == `TSWD_IMASK_OFF);
    assign hit_lock = (a == `TSWD_LOCK_OFF);
    assign mapped   = (paddr[31:`TSWD_ADDR_W] == '0) && (paddr[1:0] == 2'h0)
                      && (hit_load || hit_ctrl || hit_ris || hit_mask || hit_lock
                      || a == `TSWD_VALUE_OFF || a == `TSWD_MIS_OFF);

    // Write lands only in the access cycle that completes
    assign wr_acc   = ce && psel && penable && r_reg.pready && pwrite && !r_reg.pslverr;
    assign setup    = psel && !penable && !r_reg.pready;
    assign running  = r_reg.en;
    assign tick     = ce && running && !(r_reg.stall_en && dbg_halt);
    assign load_wr  = wr_acc && hit_load && !r_reg.locked;
    assign clr_tmo  = wr_acc && hit_ris && pwdata[`TSWD_TMO_BIT];

    always_comb
    begin
        rdata = 32'h0000_0000;
        case (a)
            `TSWD_LOAD_OFF:  rdata = r_reg.load;
            `TSWD_VALUE_OFF: rdata = r_reg.cnt;
            `TSWD_CTRL_OFF:
            begin
                rdata[`TSWD_CTRL_EN_BIT]  = r_reg.en;
                rdata[`TSWD_CTRL_RST_BIT] = r_reg.rst_en;
                rdata[`TSWD_CTRL_STL_BIT] = r_reg.stall_en;
            end
            `TSWD_RIS_OFF:   rdata[`TSWD_TMO_BIT] = r_reg.raw;
            `TSWD_IMASK_OFF: rdata[`TSWD_TMO_BIT] = r_reg.mask;
            `TSWD_MIS_OFF:   rdata[`TSWD_TMO_BIT] = r_reg.raw && r_reg.mask;
            `TSWD_LOCK_OFF:  rdata[0] = r_reg.locked;
            default:         rdata = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        r_next  = r_reg;
        set_tmo = 1'b0;

        // Bus answer one cycle after setup
        r_next.pready  = setup;
        r_next.pslverr = setup && !mapped;
        if (setup)
        begin
            r_next.prdata = mapped ? rdata : 32'h0000_0000;
        end

        // Counter
        if (tick)
        begin
            if (r_reg.cnt == '0)
            begin
                set_tmo    = 1'b1;
                r_next.cnt = r_reg.load;
                if (r_reg.raw && r_reg.rst_en)
                begin
                    r_next.sys_rst = 1'b1;
                end
            end
            else
            begin
                r_next.cnt = r_reg.cnt - 1'b1;
            end
        end

        // Configuration writes, refused while locked except writes to the lock register
        if (load_wr)
        begin
            r_next.load = pwdata;
            if (running)
            begin
                r_next.cnt = pwdata;
            end
            if (pwdata == 32'h0000_0000)
            begin
                set_tmo = 1'b1;
            end
        end
        if (wr_acc && hit_ctrl && !r_reg.locked)
        begin
            r_next.en       = pwdata[`TSWD_CTRL_EN_BIT];
            r_next.rst_en   = pwdata[`TSWD_CTRL_RST_BIT];
            r_next.stall_en = pwdata[`TSWD_CTRL_STL_BIT];
            if (pwdata[`TSWD_CTRL_EN_BIT])
            begin
                r_next.mask = 1'b1;
                if (!r_reg.en && !load_wr)
                begin
                    r_next.cnt = r_reg.load;
                end
            end
        end
        if (wr_acc && hit_mask && !r_reg.locked)
        begin
            r_next.mask = pwdata[`TSWD_TMO_BIT];
        end
        if (wr_acc && hit_lock)
        begin
            r_next.locked = (pwdata != `TSWD_UNLOCK_KEY);
        end

        // Sticky status: a new timeout beats a clear in the same cycle
        r_next.raw = (r_reg.raw && !clr_tmo) || set_tmo;
        r_next.irq = r_next.raw && r_next.mask;

        if (!ce)
        begin
            r_next = r_reg;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            r_reg          <= '0;
            r_reg.load     <= `TSWD_LOAD_RST;
            r_reg.cnt      <= `TSWD_LOAD_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign prdata      = r_reg.prdata;
    assign pready      = r_reg.pready;
    assign pslverr     = r_reg.pslverr;
    assign irq         = r_reg.irq;
    assign sys_rst_out = r_reg.sys_rst;

    logic write_hit_ctrl;
    assign write_hit_ctrl = wr_acc && hit_ctrl;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_lock_blocks_load:
    assert property (wr_acc && hit_load && r_reg.locked |=> $stable(r_reg.load))
    else $error("Locked reload register changed");

    chk_lock_blocks_ctrl:
    assert property (write_hit_ctrl && r_reg.locked |=> r_reg.en == $past(r_reg.en)
                     && r_reg.rst_en == $past(r_reg.rst_en))
    else $error("Locked control changed");

    chk_first_timeout:
    assert property (tick && r_reg.cnt == '0 |=> r_reg.raw)
    else $error("Zero count did not raise timeout");

    chk_reload_at_zero:
    assert property (tick && r_reg.cnt == '0 && !load_wr && !write_hit_ctrl
                     |=> r_reg.cnt == $past(r_reg.load))
    else $error("Counter not reloaded at zero");

    chk_second_timeout_rst:
    assert property (tick && r_reg.cnt == '0 && r_reg.raw && r_reg.rst_en
                     |=> sys_rst_out)
    else $error("Second timeout did not reset");

    chk_no_rst_when_cleared:
    assert property (!r_reg.raw && !sys_rst_out |=> !sys_rst_out)
    else $error("Reset without pending timeout");

    chk_decrement_step:
    assert property (tick && r_reg.cnt != '0 && !load_wr && !write_hit_ctrl
                     |=> r_reg.cnt == $past(r_reg.cnt) - 1'b1)
    else $error("Counter did not drop by one");

    chk_stall_hold:
    assert property (ce && r_reg.en && r_reg.stall_en && dbg_halt && !load_wr
                     && !write_hit_ctrl |=> $stable(r_reg.cnt))
    else $error("Counter moved during debug halt");

    chk_load_now:
    assert property (load_wr && running |=> r_reg.cnt == $past(pwdata))
    else $error("Running reload write not taken");

    chk_zero_load_irq:
    assert property (load_wr && pwdata == 32'h0000_0000 |=> r_reg.raw)
    else $error("Zero reload gave no timeout");

    chk_enable_unmasks:
    assert property (write_hit_ctrl && !r_reg.locked && pwdata[`TSWD_CTRL_EN_BIT]
                     |=> r_reg.mask)
    else $error("Enable did not unmask timeout");

    chk_irq_level:
    assert property (ce && $past(ce) |-> irq == ($past(r_next.raw) && $past(r_next.mask)))
    else $error("Interrupt output wrong");

    chk_answer_time:
    assert property (ce && psel && !penable && !pready |=> pready)
    else $error("Bus answer late");

    chk_pready_pulse:
    assert property (ce && pready |=> !pready)
    else $error("Bus answer held too long");

    chk_slverr_unmapped:
    assert property (ce && setup && !mapped |=> pslverr)
    else $error("Unmapped access not flagged");

    chk_slverr_with_ready:
    assert property (pslverr |-> pready)
    else $error("Error flag without answer");

    chk_err_read_zero:
    assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("Refused access returned data");

    chk_write_needs_ready:
    assert property (wr_acc |-> pready)
    else $error("Write landed outside access");

    chk_clear_drops_raw:
    assert property (clr_tmo && !set_tmo |=> !r_reg.raw)
    else $error("Timeout status not cleared");

    chk_set_beats_clear:
    assert property (set_tmo |=> r_reg.raw)
    else $error("New timeout lost");

    chk_sys_rst_sticky:
    assert property (sys_rst_out |=> sys_rst_out)
    else $error("System reset dropped early");

    chk_no_reset_disabled:
    assert property (!r_reg.rst_en && !sys_rst_out |=> !sys_rst_out)
    else $error("Reset raised while disabled");

    chk_ce_freeze:
    assert property (!ce |=> $stable(r_reg))
    else $error("State moved with clock enable low");

    chk_lock_blocks_mask:
    assert property (wr_acc && hit_mask && r_reg.locked |=> $stable(r_reg.mask))
    else $error("Locked mask changed");

    chk_lock_state:
    assert property (wr_acc && hit_lock
                     |=> r_reg.locked == ($past(pwdata) != `TSWD_UNLOCK_KEY))
    else $error("Lock state wrong after write");

    chk_enable_loads:
    assert property (write_hit_ctrl && !r_reg.locked && !r_reg.en
                     && pwdata[`TSWD_CTRL_EN_BIT] |=> r_reg.cnt == $past(r_reg.load))
    else $error("Enable did not load counter");

    chk_idle_holds:
    assert property (ce && !r_reg.en && !load_wr && !write_hit_ctrl
                     |=> $stable(r_reg.cnt))
    else $error("Counter moved while disabled");

    chk_disabled_quiet:
    assert property (ce && !r_reg.en && !load_wr && !r_reg.raw |=> !r_reg.raw)
    else $error("Timeout while disabled");

    chk_irq_needs_mask:
    assert property (irq |-> r_reg.raw && r_reg.mask)
    else $error("Interrupt without masked status");

    chk_value_read:
    assert property (ce && setup && mapped && a == `TSWD_VALUE_OFF
                     |=> prdata == $past(r_reg.cnt))
    else $error("Counter read wrong");

    chk_lock_read:
    assert property (ce && setup && mapped && hit_lock
                     |=> prdata == {31'h0000_0000, $past(r_reg.locked)})
    else $error("Lock read wrong");

    chk_mis_read:
    assert property (ce && setup && mapped && a == `TSWD_MIS_OFF
                     |=> prdata[0] == ($past(r_reg.raw) && $past(r_reg.mask)))
    else $error("Masked status read wrong");

    chk_ris_read:
    assert property (ce && setup && mapped && hit_ris
                     |=> prdata[0] == $past(r_reg.raw))
    else $error("Raw status read wrong");

endmodule

`default_nettype wire
